// File: verilog/ptif_regs.svh
// register offsets, field positions and reset values of the cause block
`ifndef PTIF_REGS_SVH
`define PTIF_REGS_SVH
`define PTIF_ENABLES_OFS   16'h540a
`define PTIF_FLAGS_OFS     16'h540c
`define PTIF_CMP_A_BIT     0
`define PTIF_CMP_B_BIT     1
`define PTIF_CAP_A_BIT     2
`define PTIF_CAP_B_BIT     3
`define PTIF_CAP_A_OVR_BIT 4
`define PTIF_CAP_B_OVR_BIT 5
`define PTIF_NUM_CAUSES    6
`define PTIF_FLAGS_RST     6'h00
`define PTIF_ENABLES_RST   6'h00
`endif

// File: verilog/ptif_pkg.sv
// types shared by the cause block
`default_nettype none
package ptif_pkg;
	typedef logic [5:0]  ptif_cause_t;
	typedef logic [15:0] ptif_word_t;
endpackage
`default_nettype wire

// File: verilog/ptif_irq_flags.sv
// sticky cause flags, enables and request output of one timer channel
// Functional notes
// - Overrun causes of capture B and A request only while enable bits 5 and 4 are 1.
// - Capture B and A causes request only while enable bits 3 and 2 are 1.
// - Compare B and A causes request only while enable bits 1 and 0 are 1.
// - All six enable bits read 0 after reset.
// - The capture B overrun flag, bit 5, is set when capture B is overwritten.
// - The capture A overrun flag, bit 4, is set when capture A is overwritten.
// - The capture B flag, bit 3, is set on each load of capture B.
// - The capture A flag, bit 2, is set on each load of capture A.
// - The compare B flag, bit 1, is set when the counter reaches compare B.
// - The compare A flag, bit 0, is set when the counter reaches compare A.
// - Writing 1 to a flag clears it unless its event arrives in the same cycle, and writing 0 leaves it unchanged.
// - All six flags read 0 after reset.
// - A capture on the selected trigger edge raises the capture cause.
// - A compare B match raises its cause in the cycle the counter restarts.
`include "ptif_regs.svh"
`default_nettype none

module ptif_irq_flags
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output var  logic [15:0] rdata_o,
	input  wire logic        cmp_a_match_i,
	input  wire logic        cmp_b_match_i,
	input  wire logic        cap_a_load_i,
	input  wire logic        cap_b_load_i,
	output var  logic        irq_o
);

////////////////////////////////////////////////////////////////////////////////
// state registers and their next values

	ptif_pkg::ptif_cause_t flags_r;
	ptif_pkg::ptif_cause_t flags_nxt;
	ptif_pkg::ptif_cause_t enables_r;
	ptif_pkg::ptif_cause_t enables_nxt;
	logic                  cap_a_full_r;
	logic                  cap_a_full_nxt;
	logic                  cap_b_full_r;
	logic                  cap_b_full_nxt;
	ptif_pkg::ptif_word_t  rdata_nxt;
	logic                  irq_nxt;

////////////////////////////////////////////////////////////////////////////////
// decoded bus strobes and event vectors

	logic                  flags_wr;
	logic                  flags_rd;
	logic                  enables_wr;
	logic                  enables_rd;
	ptif_pkg::ptif_cause_t clear_v;
	ptif_pkg::ptif_cause_t set_v;
	ptif_pkg::ptif_cause_t pending_v;

////////////////////////////////////////////////////////////////////////////////
// helper functions

	// address match of one register
	function automatic logic hit
	(
		input logic [15:0] a,
		input logic [15:0] ofs
	);
		hit = (a == ofs);
	endfunction

	// one sticky bit: a new event wins over a clear
	function automatic logic sticky
	(
		input logic old_b,
		input logic clr_b,
		input logic new_b
	);
		sticky = (old_b & ~clr_b) | new_b;
	endfunction

	// cause vector widened to the bus word
	function automatic ptif_pkg::ptif_word_t widen
	(
		input ptif_pkg::ptif_cause_t v
	);
		widen = {10'h000, v};
	endfunction

	// one cause passed on only while enabled
	function automatic logic gate
	(
		input logic f,
		input logic e
	);
		gate = f & e;
	endfunction

////////////////////////////////////////////////////////////////////////////////
// register address decode

	always_comb
	begin
		flags_wr   = wr_i && hit(addr_i, `PTIF_FLAGS_OFS);
		flags_rd   = rd_i && hit(addr_i, `PTIF_FLAGS_OFS);
		enables_wr = wr_i && hit(addr_i, `PTIF_ENABLES_OFS);
		enables_rd = rd_i && hit(addr_i, `PTIF_ENABLES_OFS);
	end

////////////////////////////////////////////////////////////////////////////////
// event and clear vectors

	always_comb
	begin
		set_v = '0;
		set_v[`PTIF_CMP_A_BIT] = cmp_a_match_i;
		set_v[`PTIF_CMP_B_BIT] = cmp_b_match_i;
		set_v[`PTIF_CAP_A_BIT] = cap_a_load_i;
		set_v[`PTIF_CAP_B_BIT] = cap_b_load_i;
		// overwrite: a new load while the previous capture flag is still set
		set_v[`PTIF_CAP_A_OVR_BIT] =
			cap_a_load_i & cap_a_full_r;
		set_v[`PTIF_CAP_B_OVR_BIT] =
			cap_b_load_i & cap_b_full_r;
		clear_v = '0;
		if (flags_wr)
		begin
			clear_v = wdata_i[5:0];
		end
	end

////////////////////////////////////////////////////////////////////////////////
// cause flags

	always_comb
	begin
		flags_nxt = flags_r;
		flags_nxt[`PTIF_CMP_A_BIT] = sticky(
			flags_r[`PTIF_CMP_A_BIT],
			clear_v[`PTIF_CMP_A_BIT],
			set_v[`PTIF_CMP_A_BIT]);

		flags_nxt[`PTIF_CMP_B_BIT] = sticky(
			flags_r[`PTIF_CMP_B_BIT],
			clear_v[`PTIF_CMP_B_BIT],
			set_v[`PTIF_CMP_B_BIT]);

		flags_nxt[`PTIF_CAP_A_BIT] = sticky(
			flags_r[`PTIF_CAP_A_BIT],
			clear_v[`PTIF_CAP_A_BIT],
			set_v[`PTIF_CAP_A_BIT]);

		flags_nxt[`PTIF_CAP_B_BIT] = sticky(
			flags_r[`PTIF_CAP_B_BIT],
			clear_v[`PTIF_CAP_B_BIT],
			set_v[`PTIF_CAP_B_BIT]);

		flags_nxt[`PTIF_CAP_A_OVR_BIT] = sticky(
			flags_r[`PTIF_CAP_A_OVR_BIT],
			clear_v[`PTIF_CAP_A_OVR_BIT],
			set_v[`PTIF_CAP_A_OVR_BIT]);

		flags_nxt[`PTIF_CAP_B_OVR_BIT] = sticky(
			flags_r[`PTIF_CAP_B_OVR_BIT],
			clear_v[`PTIF_CAP_B_OVR_BIT],
			set_v[`PTIF_CAP_B_OVR_BIT]);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			flags_r <= `PTIF_FLAGS_RST;
		end
		else
		begin
			flags_r <= flags_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// interrupt enables

	always_comb
	begin
		enables_nxt = enables_r;
		if (enables_wr)
		begin
			enables_nxt = wdata_i[5:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			enables_r <= `PTIF_ENABLES_RST;
		end
		else
		begin
			enables_r <= enables_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// capture held until its flag is cleared by software

	always_comb
	begin
		cap_a_full_nxt = flags_nxt[`PTIF_CAP_A_BIT];
		cap_b_full_nxt = flags_nxt[`PTIF_CAP_B_BIT];
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cap_a_full_r <= 1'b0;
			cap_b_full_r <= 1'b0;
		end
		else
		begin
			cap_a_full_r <= cap_a_full_nxt;
			cap_b_full_r <= cap_b_full_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// read data, standing for the one cycle after the strobe

	always_comb
	begin
		rdata_nxt = '0;
		if (flags_rd)
		begin
			rdata_nxt = widen(flags_r);
		end
		else if (enables_rd)
		begin
			rdata_nxt = widen(enables_r);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rdata_o <= 16'h0000;
		end
		else
		begin
			rdata_o <= rdata_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// request to the interrupt controller

	always_comb
	begin
		pending_v = '0;
		// next-state values: the request rises with its flag
		pending_v[`PTIF_CMP_A_BIT] = gate(
			flags_nxt[`PTIF_CMP_A_BIT],
			enables_nxt[`PTIF_CMP_A_BIT]);
		pending_v[`PTIF_CMP_B_BIT] = gate(
			flags_nxt[`PTIF_CMP_B_BIT],
			enables_nxt[`PTIF_CMP_B_BIT]);
		pending_v[`PTIF_CAP_A_BIT] = gate(
			flags_nxt[`PTIF_CAP_A_BIT],
			enables_nxt[`PTIF_CAP_A_BIT]);
		pending_v[`PTIF_CAP_B_BIT] = gate(
			flags_nxt[`PTIF_CAP_B_BIT],
			enables_nxt[`PTIF_CAP_B_BIT]);
		pending_v[`PTIF_CAP_A_OVR_BIT] = gate(
			flags_nxt[`PTIF_CAP_A_OVR_BIT],
			enables_nxt[`PTIF_CAP_A_OVR_BIT]);
		pending_v[`PTIF_CAP_B_OVR_BIT] = gate(
			flags_nxt[`PTIF_CAP_B_OVR_BIT],
			enables_nxt[`PTIF_CAP_B_OVR_BIT]);
		irq_nxt = |pending_v;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= irq_nxt;
		end
	end

endmodule // ptif_irq_flags
`default_nettype wire

// File: verification/ptif_sink.sv
// interrupt controller stand-in: registers the request
`default_nettype none
module ptif_sink
(
	input  wire logic clk_i,
	input  wire logic irq_i,
	output var  logic seen_o
);
	always @(posedge clk_i) seen_o <= irq_i;
endmodule // ptif_sink
`default_nettype wire

// File: verification/ptif_irq_flags_assertions.sv
// port checks of the cause block
`default_nettype none
module ptif_chk
(
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        cmp_a_match_i,
	input wire logic        cmp_b_match_i,
	input wire logic        cap_a_load_i,
	input wire logic        cap_b_load_i,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire ev = cmp_a_match_i | cmp_b_match_i | cap_a_load_i | cap_b_load_i;
	sequence rdf; rd_i && addr_i == 16'h540c; endsequence
	rst_quiet_a:
	assert property ($fell(sys_rst_i) |-> !irq_o && !rdata_o) else $error("rst");
	irq_hold_a:
	assert property (!wr_i && !ev |=> $stable(irq_o)) else $error("irq moved");
	mask_off_a:
	assert property (wr_i && addr_i == 16'h540a &&
		wdata_i[5:0] == 6'h00 |=> !irq_o) else $error("irq masked");
	clr_all_a:
	assert property (wr_i && addr_i == 16'h540c &&
		&wdata_i[5:0] && !ev |=> !irq_o) else $error("irq cleared");
	cmp_a_set_a:
	assert property (cmp_a_match_i ##1 rdf |=> rdata_o[0]) else $error("cmp");
	cmp_b_set_a:
	assert property (cmp_b_match_i ##1 rdf |=> rdata_o[1]) else $error("cmp");
	cap_a_set_a:
	assert property (cap_a_load_i ##1 rdf |=> rdata_o[2]) else $error("cap");
	cap_b_set_a:
	assert property (cap_b_load_i ##1 rdf |=> rdata_o[3]) else $error("cap");
	ovr_a_set_a:
	assert property (cap_a_load_i[*2] ##1 rdf |=> rdata_o[4]) else $error("ovr");
	ovr_b_set_a:
	assert property (cap_b_load_i[*2] ##1 rdf |=> rdata_o[5]) else $error("ovr");
endmodule // ptif_chk
bind ptif_irq_flags ptif_chk i_chk (.*);
`default_nettype wire

// File: verification/ptif_irq_flags_bench.sv
// self-checking bench of the cause block
`default_nettype none
module ptif_irq_flags_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'h0, sys_rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, irq_o, seen;
	logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o;
	logic [3:0] ev = 4'h0;
	int fail_count = 0, checks_done = 0, cyc = 0;
	always #10 clk_i = ~clk_i;
	ptif_irq_flags i_dut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .cmp_a_match_i(ev[0]), .cmp_b_match_i(ev[1]),
		.cap_a_load_i(ev[2]), .cap_b_load_i(ev[3]), .irq_o);
	ptif_sink i_sink (.clk_i, .irq_i(irq_o), .seen_o(seen));
	always @(posedge clk_i) if (++cyc == 900) final_report();
	task automatic chk(input string n, input logic [15:0] e, g);
		checks_done++;
		fail_count += int'(g !== e);
		if (g !== e) $display("ERROR %s exp %h got %h", n, e, g);
	endtask
	task automatic wr(input logic [15:0] a, d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clk_i) wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a, d, input logic q);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i) rd_i <= 1'h0;
		@(negedge clk_i) chk("rdata", d, rdata_o);
		chk("irq", {14'h0, q, q}, {14'h0, seen, irq_o});
		@(posedge clk_i);
	endtask
	task automatic final_report;
		if (cyc >= 900) fail_count++;
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic reset_values;
		rd(16'h540a, 16'h0000, 1'h0);
		rd(16'h540c, 16'h0000, 1'h0);
	endtask
	task automatic cause_masking;
		for (int i = 0; i < 4; i++)
		begin
			wr(16'h540a, 16'h0001 << ((i + 1) % 4));
			ev <= 4'h1 << i;
			@(posedge clk_i) ev <= 4'h0;
			rd(16'h540c, 16'h0001 << i, 1'h0);
			wr(16'h540a, 16'h0001 << i);
			rd(16'h540c, 16'h0001 << i, 1'h1);
			wr(16'h540c, 16'h0001 << i);
			rd(16'h540c, 16'h0000, 1'h0);
		end
	endtask
	task automatic overrun;
		wr(16'h540a, 16'h0030);
		ev <= 4'hc;
		repeat (2) @(posedge clk_i);
		ev <= 4'h0;
		rd(16'h540c, 16'h003c, 1'h1);
		wr(16'h540c, 16'h0000);
		rd(16'h540c, 16'h003c, 1'h1);
		wr(16'h540a, 16'h0000);
		rd(16'h540c, 16'h003c, 1'h0);
		wr(16'h540c, 16'h003f);
		rd(16'h540c, 16'h0000, 1'h0);
	endtask
	task automatic set_wins;
		ev <= 4'h1;
		wr(16'h540c, 16'h0001);
		ev <= 4'h0;
		rd(16'h540c, 16'h0001, 1'h0);
		wr(16'h540c, 16'h0001);
		rd(16'h540c, 16'h0000, 1'h0);
	endtask
	task automatic reset_again;
		wr(16'h540a, 16'h003f);
		ev <= 4'h1;
		@(posedge clk_i) ev <= 4'h0;
		rd(16'h540c, 16'h0001, 1'h1);
		sys_rst_i <= 1'h1;
		@(posedge clk_i) sys_rst_i <= 1'h0;
		rd(16'h540a, 16'h0000, 1'h0);
		rd(16'h540c, 16'h0000, 1'h0);
	endtask
	task automatic unmapped;
		rd(16'h540e, 16'h0000, 1'h0);
		wr(16'h540e, 16'h003f);
		rd(16'h540a, 16'h0000, 1'h0);
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		reset_values();
		cause_masking();
		overrun();
		set_wins();
		reset_again();
		unmapped();
		final_report();
	end
endmodule // ptif_irq_flags_bench
`default_nettype wire
